// ===== chst_card_host.sv
// card host: card clock, command engine and one/four lane data engine
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Overview of operation
// - sd mode: width bit picks one/four lanes
// - multimedia cards use data lane zero only
// - command sent serially, addressed or broadcast
// - data lanes carry reads and writes
// - all bits timed by our card clock
// - command then response, data when moving
// - stream runs until stop command
// - each data block followed by crc
// - multi block ends on stop or count
// - no bus activity until enable set
// - idle power save divides card clock
// - guard modes halt clock while fifo full
// - command line open-drain or push-pull per command
// - response kind two captures 136 bits
// - latency select zero allows five cycles
// - transfer fields ignored without transfer command
// - special selects zero mean ordinary command
// - index two broadcast with long response
// - argument sent in command content field
// - four-lane sd lane one interrupt, sd lane three detect
// - command starts on command write
// ****************************************

module chst_card_host
	import chst_pkg::*;
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// mode and control
	input wire logic i_host_enable_bit,
	input wire logic i_sd_card_mode,
	input wire logic i_sd_bus_width_sel,
	input wire logic i_power_save_enable,
	input wire logic [2:0] i_power_save_divider,
	input wire logic i_read_fifo_guard,
	input wire logic i_write_fifo_guard,
	input wire logic i_fifo_full,
	input wire logic [11:0] i_block_len,
	input wire logic [15:0] i_block_count,
	// command register write
	input wire logic i_cmd_write,
	input wire logic [31:0] i_argument,
	input wire logic [5:0] i_command_index,
	input wire logic [1:0] i_response_kind,
	input wire logic [2:0] i_special_cmd_sel,
	input wire logic i_open_drain_sel,
	input wire logic i_response_latency_sel,
	input wire logic [1:0] i_transfer_cmd_sel,
	input wire logic i_transfer_direction,
	input wire logic [2:0] i_transfer_kind,
	input wire logic [1:0] i_sdio_special_cmd_sel,
	// fifo side data
	input wire logic [3:0] i_tx_data,
	output logic o_tx_take,
	output logic [3:0] o_rx_data,
	output logic o_rx_valid,
	// status
	output logic o_cmd_ready,
	output logic o_rsp_done,
	output logic o_rsp_crc_err,
	output logic o_rsp_timeout,
	output logic [135:0] o_response,
	output logic o_xfer_done,
	output logic o_data_crc_err,
	output logic o_card_irq,
	output logic o_card_present,
	// card pins
	output logic o_card_clock_pin,
	input wire logic i_card_cmd_pin,
	output logic o_card_cmd_pin,
	output logic o_card_cmd_pin_oe_n,
	input wire logic [3:0] i_card_data_pins,
	output logic [3:0] o_card_data_pins,
	output logic [3:0] o_card_data_pins_oe_n
);

	// ****************************************
	// state and command fields
	// ****************************************
	chst_cmd_e cmd_st_q;
	chst_dat_e dat_st_q;
	logic clk_q;
	logic [7:0] div_q;
	logic [7:0] bcnt_q;
	logic [47:0] tx_sr_q;
	logic [135:0] rsp_sr_q;
	logic [1:0] rsp_q;
	logic [1:0] transfer_cmd_sel_q;
	logic od_q, lat_q, dir_q, stream_q, single_q;
	logic x_rd_q, x_stream_q, x_single_q, wide_q, stop_q;
	logic [14:0] beat_q;
	logic [15:0] blk_q;
	logic [6:0] crc_tx_w, crc_rx_w;
	logic [15:0] dat_crc_w [4];
	logic [3:0] dat_shift_w, dat_bit_w, crc_bits_w, crc_bad_w;

	// ****************************************
	// card clock generation
	// ****************************************
	// power save stretches the clock only when idle
	wire bus_idle_w = (cmd_st_q == C_IDLE) && (dat_st_q == D_IDLE);
	wire ps_on_w = i_power_save_enable && bus_idle_w;
	wire [7:0] half_w = ps_on_w ? 8'(9'h001 << i_power_save_divider) : 8'h01;
	wire guard_w = i_fifo_full && (dat_st_q != D_IDLE)
		&& (x_rd_q ? i_read_fifo_guard : i_write_fifo_guard);
	// guard lets a high clock fall, then parks it
	wire run_w = i_host_enable_bit && !(guard_w && !clk_q);
	wire tog_w = run_w && (div_q >= half_w - 8'h01);
	wire rise_w = tog_w && !clk_q; // sample edge
	wire fall_w = tog_w && clk_q;  // launch edge

	// clock divider
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			clk_q <= 1'b0;
			div_q <= 8'h00;
		end else if (!i_host_enable_bit) begin
			clk_q <= 1'b0;
			div_q <= 8'h00;
		end else if (tog_w) begin
			clk_q <= !clk_q;
			div_q <= 8'h00;
		end else if (run_w) begin
			div_q <= div_q + 8'h01;
		end
	end

	assign o_card_clock_pin = clk_q;

	// ****************************************
	// command engine decode
	// ****************************************
	wire long_w = (rsp_q == RSP_136);
	wire [7:0] rsp_len_w = long_w ? RSP_LONG : RSP_SHORT;
	wire [7:0] lat_w = lat_q ? LAT_EXT : LAT_NID;
	wire [7:0] crc_lo_w = long_w ? RSP_LONG_CRC_FIRST : 8'h00;
	wire crc_slot_w = (bcnt_q >= CMD_CRC_FIRST) && (bcnt_q < CMD_END_BIT);
	wire [2:0] crc_idx_w = 3'(CMD_END_BIT - 8'h01 - bcnt_q);
	wire tx_bit_w = crc_slot_w ? crc_tx_w[crc_idx_w] : tx_sr_q[47];
	wire rsp_start_w = rise_w && (cmd_st_q == C_WAIT) && !i_card_cmd_pin;
	wire rsp_tmo_w = rise_w && (cmd_st_q == C_WAIT) && i_card_cmd_pin && (bcnt_q == lat_w);
	wire rsp_last_w = rise_w && (cmd_st_q == C_RX) && (bcnt_q == rsp_len_w - 8'h01);
	wire crc_tx_sh_w = fall_w && (cmd_st_q == C_TX) && (bcnt_q < CMD_CRC_FIRST);
	wire crc_rx_sh_w = (rsp_start_w && !long_w) || (rise_w && (cmd_st_q == C_RX)
		&& (bcnt_q >= crc_lo_w) && (bcnt_q < rsp_len_w - 8'h01));
	wire cmd_go_w = i_cmd_write && (cmd_st_q == C_IDLE);

	// command and response crc
	chst_crc_ser #(.W(7), .POLY(CRC7_POLY)) u_crc_tx (
		.i_sys_clk(i_sys_clk),
		.i_sys_rst(i_sys_rst),
		.i_clear(cmd_go_w),
		.i_shift(crc_tx_sh_w),
		.i_bit(tx_sr_q[47]),
		.o_crc(crc_tx_w)
	);
	chst_crc_ser #(.W(7), .POLY(CRC7_POLY)) u_crc_rx (
		.i_sys_clk(i_sys_clk),
		.i_sys_rst(i_sys_rst),
		.i_clear(cmd_go_w),
		.i_shift(crc_rx_sh_w),
		.i_bit(i_card_cmd_pin),
		.o_crc(crc_rx_w)
	);

	// command sequencer; special selects not decoded
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cmd_st_q <= C_IDLE;
			bcnt_q <= CMD_IDLE_RESET;
			tx_sr_q <= '0;
			{rsp_q, transfer_cmd_sel_q, od_q, lat_q, dir_q, stream_q, single_q} <= '0;
			o_card_cmd_pin <= 1'b1;
			o_card_cmd_pin_oe_n <= 1'b1;
		end else if (!i_host_enable_bit) begin
			cmd_st_q <= C_IDLE;
			o_card_cmd_pin <= 1'b1;
			o_card_cmd_pin_oe_n <= 1'b1;
		end else begin
			case (cmd_st_q)
				C_IDLE: if (cmd_go_w) begin
					// argument taken at command write
					tx_sr_q <= {2'b01, i_command_index, i_argument, 7'h00, 1'b1};
					rsp_q <= i_response_kind;
					od_q <= i_open_drain_sel;
					lat_q <= i_response_latency_sel;
					transfer_cmd_sel_q <= i_transfer_cmd_sel;
					dir_q <= i_transfer_direction;
					stream_q <= (i_transfer_kind == KIND_STREAM);
					single_q <= (i_transfer_kind == KIND_SINGLE);
					bcnt_q <= 8'h00;
					cmd_st_q <= C_TX;
				end
				C_TX: if (fall_w) begin
					if (bcnt_q == CMD_BITS) begin
						o_card_cmd_pin <= 1'b1; // to pull-up
						o_card_cmd_pin_oe_n <= 1'b1;
						bcnt_q <= 8'h00;
						cmd_st_q <= (rsp_q == RSP_NONE) ? C_DONE : C_WAIT;
					end else begin
						// open drain only pulls low
						o_card_cmd_pin <= od_q ? 1'b0 : tx_bit_w;
						o_card_cmd_pin_oe_n <= od_q & tx_bit_w;
						tx_sr_q <= {tx_sr_q[46:0], 1'b0};
						bcnt_q <= bcnt_q + 8'h01;
					end
				end
				C_WAIT: if (rise_w) begin
					if (rsp_start_w) begin
						bcnt_q <= 8'h01;
						cmd_st_q <= C_RX;
					end else if (rsp_tmo_w) begin
						cmd_st_q <= C_DONE;
					end else begin
						bcnt_q <= bcnt_q + 8'h01;
					end
				end
				C_RX: if (rise_w) begin
					bcnt_q <= bcnt_q + 8'h01;
					if (rsp_last_w) begin
						cmd_st_q <= C_DONE;
					end
				end
				C_DONE: cmd_st_q <= C_IDLE;
				default: cmd_st_q <= C_IDLE;
			endcase
		end
	end

	// response capture and status
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rsp_sr_q <= '0;
			o_response <= '0;
			{o_rsp_done, o_rsp_crc_err, o_rsp_timeout, o_cmd_ready} <= '0;
		end else begin
			o_cmd_ready <= i_host_enable_bit && (cmd_st_q == C_IDLE) && !i_cmd_write;
			o_rsp_done <= (cmd_st_q == C_DONE);
			if (cmd_go_w) begin
				rsp_sr_q <= '0;
			end else if (rsp_start_w || (rise_w && (cmd_st_q == C_RX))) begin
				rsp_sr_q <= {rsp_sr_q[134:0], i_card_cmd_pin};
			end
			if (rsp_last_w) begin
				o_response <= {rsp_sr_q[134:0], i_card_cmd_pin};
			end
			if (rsp_last_w) begin
				o_rsp_crc_err <= (crc_rx_w != 7'h00);
			end else if (cmd_go_w) begin
				o_rsp_crc_err <= 1'b0;
			end
			if (rsp_tmo_w) begin
				o_rsp_timeout <= 1'b1;
			end else if (cmd_go_w) begin
				o_rsp_timeout <= 1'b0;
			end
		end
	end

	// ****************************************
	// data engine decode
	// ****************************************
	wire dat_go_w = (cmd_st_q == C_DONE) && (transfer_cmd_sel_q == XFER_START) && (dat_st_q == D_IDLE);
	wire stop_w = (cmd_st_q == C_DONE) && (transfer_cmd_sel_q == XFER_STOP) && (dat_st_q != D_IDLE);
	wire [3:0] mask_w = wide_q ? 4'hF : 4'h1;
	wire [14:0] beats_w = wide_q ? {2'b00, i_block_len, 1'b0} : {i_block_len, 3'b000};
	wire ev_w = x_rd_q ? rise_w : fall_w;
	wire last_beat_w = (beat_q == beats_w - 15'h0001);
	wire blk_fin_w = x_single_q || stop_q
		|| ((i_block_count != 16'h0000) && (blk_q + 16'h0001 == i_block_count));
	wire blk_end_w = ev_w && ((x_rd_q && (dat_st_q == D_END)) || (!x_rd_q
		&& (dat_st_q == D_BUSY) && (beat_q >= WR_BUSY_GAP) && i_card_data_pins[0]));
	wire dat_done_w = (blk_end_w && blk_fin_w)
		|| ((dat_st_q == D_START) && x_rd_q && stop_q)
		|| ((dat_st_q == D_DATA) && x_stream_q && stop_q && ev_w);
	wire crc_clr_w = (dat_st_q == D_START);

	// per-lane data crc
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			assign dat_bit_w[g] = x_rd_q ? i_card_data_pins[g] : i_tx_data[g];
			assign dat_shift_w[g] = mask_w[g] && ev_w
				&& ((dat_st_q == D_DATA) || (x_rd_q && (dat_st_q == D_CRC)));
			assign crc_bits_w[g] = dat_crc_w[g][DATA_CRC_LAST - beat_q[3:0]];
			assign crc_bad_w[g] = mask_w[g] && (dat_crc_w[g] != 16'h0000);
			chst_crc_ser #(.W(16), .POLY(CRC16_POLY)) u_crc (
				.i_sys_clk(i_sys_clk),
				.i_sys_rst(i_sys_rst),
				.i_clear(crc_clr_w),
				.i_shift(dat_shift_w[g]),
				.i_bit(dat_bit_w[g]),
				.o_crc(dat_crc_w[g])
			);
		end
	endgenerate

	// data sequencer
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			dat_st_q <= D_IDLE;
			{x_rd_q, x_stream_q, x_single_q, wide_q} <= '0;
			beat_q <= '0;
			blk_q <= '0;
			o_card_data_pins <= 4'hF;
			o_card_data_pins_oe_n <= 4'hF;
		end else if (!i_host_enable_bit) begin
			dat_st_q <= D_IDLE;
			o_card_data_pins_oe_n <= 4'hF;
		end else begin
			case (dat_st_q)
				D_IDLE: begin
					o_card_data_pins_oe_n <= 4'hF;
					if (dat_go_w) begin
						x_rd_q <= dir_q;
						x_stream_q <= stream_q;
						x_single_q <= single_q;
						wide_q <= i_sd_card_mode && i_sd_bus_width_sel;
						blk_q <= 16'h0000;
						dat_st_q <= D_START;
					end
				end
				D_START: if (dat_done_w) begin
					dat_st_q <= D_IDLE;
				end else if (ev_w) begin
					beat_q <= 15'h0000;
					if (!x_rd_q) begin
						o_card_data_pins <= 4'h0;
						o_card_data_pins_oe_n <= ~mask_w;
						dat_st_q <= D_DATA;
					end else if (!i_card_data_pins[0]) begin
						dat_st_q <= D_DATA;
					end
				end
				D_DATA: if (dat_done_w) begin
					o_card_data_pins_oe_n <= 4'hF;
					dat_st_q <= D_IDLE;
				end else if (ev_w) begin
					o_card_data_pins <= i_tx_data & mask_w;
					beat_q <= beat_q + 15'h0001;
					if (!x_stream_q && last_beat_w) begin
						beat_q <= 15'h0000;
						dat_st_q <= D_CRC;
					end
				end
				D_CRC: if (ev_w) begin
					o_card_data_pins <= crc_bits_w;
					beat_q <= beat_q + 15'h0001;
					if (beat_q[3:0] == DATA_CRC_LAST) begin
						dat_st_q <= D_END;
					end
				end
				D_END, D_BUSY: if (blk_end_w) begin
					blk_q <= blk_q + 16'h0001;
					dat_st_q <= blk_fin_w ? D_IDLE : D_START;
				end else if (ev_w && (dat_st_q == D_END)) begin
					o_card_data_pins <= 4'hF;
					beat_q <= 15'h0000;
					dat_st_q <= D_BUSY;
				end else if (ev_w) begin
					o_card_data_pins_oe_n <= 4'hF;
					if (beat_q < WR_BUSY_GAP) begin
						beat_q <= beat_q + 15'h0001;
					end
				end
				default: dat_st_q <= D_IDLE;
			endcase
		end
	end

	// data status, stop request and sd side lanes
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			{stop_q, o_tx_take, o_rx_valid, o_xfer_done, o_data_crc_err} <= '0;
			{o_card_irq, o_card_present} <= '0;
			o_rx_data <= 4'h0;
		end else begin
			if (stop_w) begin
				stop_q <= 1'b1;
			end else if (dat_go_w) begin
				stop_q <= 1'b0;
			end
			o_tx_take <= !x_rd_q && ev_w && (dat_st_q == D_DATA) && !dat_done_w;
			o_rx_valid <= x_rd_q && ev_w && (dat_st_q == D_DATA) && !dat_done_w;
			if (x_rd_q && ev_w && (dat_st_q == D_DATA)) begin
				o_rx_data <= i_card_data_pins & mask_w;
			end
			o_xfer_done <= dat_done_w;
			if (blk_end_w && x_rd_q && (|crc_bad_w)) begin
				o_data_crc_err <= 1'b1;
			end else if (dat_go_w) begin
				o_data_crc_err <= 1'b0;
			end
			// lane one irq in four-lane sd while lanes idle
			o_card_irq <= i_sd_card_mode && i_sd_bus_width_sel && (dat_st_q == D_IDLE)
				&& !i_card_data_pins[1];
			o_card_present <= i_sd_card_mode && i_card_data_pins[3];
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);

	wire ps2_w = i_host_enable_bit && ps_on_w && (i_power_save_divider == 3'h2);
	sequence ps_edge_s;
		ps2_w && tog_w;
	endsequence
	sequence ps_hold_s;
		ps2_w [*3];
	endsequence

	disabled_quiet_a: assert property (!i_host_enable_bit |=> !o_card_clock_pin
		&& o_card_cmd_pin_oe_n && (&o_card_data_pins_oe_n)) else $error("bus active while off");
	ps_gap_a: assert property (ps_edge_s |=> (!tog_w || !ps2_w) [*3])
		else $error("power save clock too fast");
	ps_period_a: assert property (ps_edge_s ##1 ps_hold_s |=> tog_w || !ps2_w)
		else $error("power save clock too slow");
	guard_stop_a: assert property (guard_w && !o_card_clock_pin |=> !o_card_clock_pin)
		else $error("clock ran, fifo full");
	od_drive_a: assert property (od_q |-> !o_card_cmd_pin || o_card_cmd_pin_oe_n)
		else $error("open drain drove high");
	cmd_start_a: assert property ((cmd_st_q == C_TX) && fall_w && (bcnt_q == 8'h00)
		|=> !o_card_cmd_pin && !o_card_cmd_pin_oe_n) else $error("no start bit");
	long_rsp_a: assert property (o_rsp_done && (rsp_q == RSP_136) && !o_rsp_timeout
		|-> bcnt_q == 8'd136) else $error("long response length");
	latency_a: assert property (rise_w && (cmd_st_q == C_WAIT) && !lat_q
		&& (bcnt_q == 8'd5) && i_card_cmd_pin |=> o_rsp_timeout ##1 o_rsp_done)
		else $error("latency limit missed");
	no_xfer_a: assert property ((cmd_st_q == C_DONE) && (transfer_cmd_sel_q == XFER_NONE)
		&& (dat_st_q == D_IDLE) |=> dat_st_q == D_IDLE) else $error("data without transfer");
	lane_free_a: assert property (!wide_q |-> &o_card_data_pins_oe_n[3:1])
		else $error("upper lanes driven");
	width_pick_a: assert property (dat_go_w && i_sd_card_mode && i_sd_bus_width_sel
		|=> wide_q) else $error("four lanes not picked");

endmodule : chst_card_host

`default_nettype wire

// ===== chst_card_model.sv
// behavioural card: responses and read blocks
`timescale 1ns/100ps
`default_nettype none

module chst_card_model (
	// card pins
	input wire logic i_clk,
	input wire logic i_cmd,
	output logic o_cmd_en,
	output logic o_cmd,
	output logic o_dat_en,
	output logic [3:0] o_dat,
	// behaviour chosen by the bench
	input wire logic [7:0] i_rsp_bits,
	input wire logic [7:0] i_rsp_gap,
	input wire logic [135:0] i_rsp_val,
	input wire logic [1:0] i_rd_blk,
	// what the card received
	output logic [47:0] o_tok,
	output logic [7:0] o_tok_n
);
	// ****************
	// command, response, read blocks
	// ****************
	initial begin
		o_cmd_en = 1'b0;
		o_cmd = 1'b1;
		o_dat_en = 1'b0;
		o_dat = 4'hF;
		o_tok = '0;
		o_tok_n = 8'h00;
		forever begin
			@(posedge i_clk);
			if (i_cmd === 1'b0) begin
				o_tok[47] = 1'b0;
				for (int i = 46; i >= 0; i--) begin
					@(posedge i_clk); // card clock rise
					o_tok[i] = i_cmd;
				end
				o_tok_n = o_tok_n + 8'h01;
				// response after the bench's gap
				repeat (i_rsp_gap) @(negedge i_clk);
				o_cmd_en = (i_rsp_bits != 8'h00);
				for (int i = int'(i_rsp_bits) - 1; i >= 0; i--) begin
					o_cmd = i_rsp_val[i];
					@(negedge i_clk);
				end
				o_cmd_en = 1'b0; // pull-up takes the line
				repeat (i_rd_blk) begin
					repeat (2) @(negedge i_clk);
					o_dat_en = 1'b1;
					// start, 4 beats, 16 crc, end
					for (int i = 0; i < 22; i++) begin
						o_dat = (i == 0) ? 4'h0 : (i < 5) ? 4'(i + 4) : (i < 21) ? 4'h0 : 4'hF;
						@(negedge i_clk);
					end
					o_dat_en = 1'b0;
				end
			end
		end
	end
endmodule : chst_card_model
`default_nettype wire

// ===== chst_crc_ser.sv
// serial msb-first crc register with zero seed
`timescale 1ns/100ps
`default_nettype none

module chst_crc_ser
	import chst_pkg::*;
#(
	parameter int W = 7,
	parameter logic [15:0] POLY = 16'h0009
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// control
	input wire logic i_clear,
	input wire logic i_shift,
	input wire logic i_bit,
	// remainder
	output logic [W-1:0] o_crc
);

	// ****************************************
	// feedback
	// ****************************************
	// a good frame shifted through leaves zero
	logic [W-1:0] crc_q;
	wire fb_w = i_bit ^ crc_q[W-1];
	wire [W-1:0] crc_d = {crc_q[W-2:0], 1'b0} ^ (fb_w ? POLY[W-1:0] : {W{1'b0}});

	// register
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			crc_q <= '0;
		end else if (i_clear) begin
			crc_q <= '0;
		end else if (i_shift) begin
			crc_q <= crc_d;
		end
	end

	assign o_crc = crc_q;

endmodule : chst_crc_ser

`default_nettype wire

// ===== chst_pkg.sv
// card host package: framing, field codes and states
package chst_pkg;

	// ****************************************
	// command and response framing
	// ****************************************
	localparam logic [7:0] CMD_BITS = 8'h30;           // 48-bit command token
	localparam logic [7:0] CMD_CRC_FIRST = 8'h28;      // bit index of first crc bit
	localparam logic [7:0] CMD_END_BIT = 8'h2F;        // bit index of the end bit
	localparam logic [7:0] RSP_SHORT = 8'h30;          // 48-bit response
	localparam logic [7:0] RSP_LONG = 8'h88;           // 136-bit response
	localparam logic [7:0] RSP_LONG_CRC_FIRST = 8'h08; // long crc coverage start
	localparam logic [7:0] LAT_NID = 8'h05;            // latency select 0: 5 card cycles
	localparam logic [7:0] LAT_EXT = 8'h40;            // latency select 1: 64 card cycles
	localparam logic [7:0] CMD_IDLE_RESET = 8'h00;

	// ****************************************
	// data framing and polynomials
	// ****************************************
	localparam logic [3:0] DATA_CRC_LAST = 4'hF;       // 16 crc bits per lane
	localparam logic [14:0] WR_BUSY_GAP = 15'h0008;    // card cycles before busy check
	localparam logic [15:0] CRC7_POLY = 16'h0009;
	localparam logic [15:0] CRC16_POLY = 16'h1021;

	// ****************************************
	// command field codes
	// ****************************************
	localparam logic [1:0] RSP_NONE = 2'h0;
	localparam logic [1:0] RSP_48 = 2'h1;
	localparam logic [1:0] RSP_136 = 2'h2;
	localparam logic [1:0] RSP_48_BUSY = 2'h3;
	localparam logic [1:0] XFER_NONE = 2'h0;
	localparam logic [1:0] XFER_START = 2'h1;
	localparam logic [1:0] XFER_STOP = 2'h2;
	localparam logic [2:0] KIND_SINGLE = 3'h0;
	localparam logic [2:0] KIND_MULTI = 3'h1;
	localparam logic [2:0] KIND_STREAM = 3'h2;

	// ****************************************
	// states
	// ****************************************
	typedef enum logic [2:0] {
		C_IDLE = 3'b000, C_TX = 3'b001, C_WAIT = 3'b010, C_RX = 3'b011, C_DONE = 3'b100
	} chst_cmd_e;
	typedef enum logic [2:0] {
		D_IDLE = 3'b000, D_START = 3'b001, D_DATA = 3'b010, D_CRC = 3'b011,
		D_END = 3'b100, D_BUSY = 3'b101
	} chst_dat_e;

endpackage : chst_pkg

// ===== tb_chst_card_host.sv
// bench for the card host with a behavioural card
`timescale 1ns/100ps
`default_nettype none

module tb_chst_card_host;
	import chst_pkg::*;
	// ****************
	// signals and wiring
	// ****************
	logic i_sys_clk, i_sys_rst, i_host_enable_bit, i_sd_card_mode, i_sd_bus_width_sel;
	logic i_power_save_enable, i_read_fifo_guard, i_write_fifo_guard, i_fifo_full, i_cmd_write;
	logic [2:0] i_power_save_divider, i_special_cmd_sel, i_transfer_kind;
	logic [11:0] i_block_len;
	logic [15:0] i_block_count;
	logic [31:0] i_argument;
	logic [5:0] i_command_index;
	logic [1:0] i_response_kind, i_transfer_cmd_sel, i_sdio_special_cmd_sel, rd_blk;
	logic i_open_drain_sel, i_response_latency_sel, i_transfer_direction, o_tx_take, o_rx_valid;
	logic [3:0] i_tx_data, o_rx_data, o_card_data_pins, o_card_data_pins_oe_n, m_dat;
	logic o_cmd_ready, o_rsp_done, o_rsp_crc_err, o_rsp_timeout, o_xfer_done, o_data_crc_err;
	logic o_card_irq, o_card_present, o_card_clock_pin, o_card_cmd_pin, o_card_cmd_pin_oe_n;
	logic m_cmd_en, m_cmd, m_dat_en, ck_prev;
	logic [135:0] o_response, rsp_val;
	logic [7:0] rsp_bits, rsp_gap, tok_n;
	logic [47:0] tok;
	logic [3:0] rx_q [$];
	int n_fail, n_compared, cyc, take_n, xd_n, dlow, hi_lane, drv_hi, ck_tg;
	// pulled-up lines; any low wins
	wire logic cmd_w = (o_card_cmd_pin | o_card_cmd_pin_oe_n) & (m_cmd_en ? m_cmd : 1'b1);
	wire logic [3:0] dat_w = (o_card_data_pins | o_card_data_pins_oe_n) & (m_dat_en ? m_dat : 4'hF);

	chst_card_host u_chst_card_host (
		.i_sys_clk, .i_sys_rst, .i_host_enable_bit, .i_sd_card_mode, .i_sd_bus_width_sel,
		.i_power_save_enable, .i_power_save_divider, .i_read_fifo_guard, .i_write_fifo_guard,
		.i_fifo_full, .i_block_len, .i_block_count, .i_cmd_write, .i_argument, .i_command_index,
		.i_response_kind, .i_special_cmd_sel, .i_open_drain_sel, .i_response_latency_sel,
		.i_transfer_cmd_sel, .i_transfer_direction, .i_transfer_kind, .i_sdio_special_cmd_sel,
		.i_tx_data, .o_tx_take, .o_rx_data, .o_rx_valid, .o_cmd_ready, .o_rsp_done,
		.o_rsp_crc_err, .o_rsp_timeout, .o_response, .o_xfer_done, .o_data_crc_err, .o_card_irq,
		.o_card_present, .o_card_clock_pin, .i_card_cmd_pin(cmd_w), .o_card_cmd_pin,
		.o_card_cmd_pin_oe_n, .i_card_data_pins(dat_w), .o_card_data_pins, .o_card_data_pins_oe_n
	);
	chst_card_model u_chst_card_model (.i_clk(o_card_clock_pin), .i_cmd(cmd_w),
		.o_cmd_en(m_cmd_en), .o_cmd(m_cmd), .o_dat_en(m_dat_en), .o_dat(m_dat),
		.i_rsp_bits(rsp_bits), .i_rsp_gap(rsp_gap), .i_rsp_val(rsp_val), .i_rd_blk(rd_blk),
		.o_tok(tok), .o_tok_n(tok_n));

	initial begin
		i_sys_clk = 1'b0;
		forever #20 i_sys_clk = ~i_sys_clk;
	end
	// pin watchers and cycle ceiling
	always @(negedge i_sys_clk) begin
		if (o_card_clock_pin !== ck_prev) ck_tg++;
		ck_prev = o_card_clock_pin;
		if (o_rx_valid === 1'b1) rx_q.push_back(o_rx_data);
		if (o_tx_take === 1'b1) take_n++;
		if (o_xfer_done === 1'b1) xd_n++;
		if (o_card_data_pins_oe_n !== 4'hF) dlow++;
		if (o_card_data_pins_oe_n[3:1] !== 3'h7) hi_lane++;
		if (o_card_cmd_pin_oe_n === 1'b0 && o_card_cmd_pin === 1'b1) drv_hi++;
		cyc++;
		if (cyc == 30000) n_fail++;
		if (cyc == 30000) summarize();
	end

	// ****************
	// shared tasks
	// ****************
	task automatic chk(input logic ok, input string msg);
		n_compared++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask : chk

	function automatic logic [47:0] tok_exp(input logic [5:0] idx, input logic [31:0] arg);
		logic [39:0] d;
		logic [6:0] c;
		d = {2'b01, idx, arg};
		c = 7'h00;
		for (int i = 39; i >= 0; i--) c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
		return {d, c, 1'b1};
	endfunction : tok_exp

	task automatic cmd(input logic [5:0] idx, input logic [31:0] arg, input logic [1:0] rk,
		input logic od, input logic lat, input logic [1:0] tc, input logic dir, input logic [2:0] kd);
		int k;
		@(negedge i_sys_clk);
		{i_command_index, i_argument, i_response_kind} = {idx, arg, rk};
		{i_open_drain_sel, i_response_latency_sel, i_transfer_cmd_sel} = {od, lat, tc};
		{i_transfer_direction, i_transfer_kind, i_cmd_write} = {dir, kd, 1'b1};
		@(negedge i_sys_clk);
		i_cmd_write = 1'b0;
		for (k = 0; k < 2000 && o_rsp_done !== 1'b1; k++) @(negedge i_sys_clk);
		chk(k < 2000 && tok === tok_exp(idx, arg), "command token");
	endtask : cmd

	task automatic wait_xd();
		for (int k = 0; k < 3000 && xd_n == 0; k++) @(negedge i_sys_clk);
	endtask : wait_xd

	// ****************
	// scenarios
	// ****************
	task automatic t_off();
		ck_tg = 0;
		i_cmd_write = 1'b1;
		@(negedge i_sys_clk);
		i_cmd_write = 1'b0;
		repeat (40) @(negedge i_sys_clk);
		chk(ck_tg == 0 && tok_n === 8'h00 && o_card_cmd_pin_oe_n === 1'b1, "busy while off");
		$display("test off done");
	endtask : t_off

	task automatic t_cid();
		rsp_val = {8'h3F, 120'h0123456789ABCDEF0123456789ABCD, 7'h55, 1'b1};
		{rsp_bits, rsp_gap, drv_hi} = {8'h88, 8'h06, 32'h0};
		cmd(6'h02, 32'hFFFF_FFFF, RSP_136, 1'b1, 1'b0, XFER_NONE, 1'b1, KIND_STREAM);
		chk(o_response === rsp_val && o_rsp_timeout === 1'b0, "long response");
		chk(drv_hi == 0, "open drain drove high");
		repeat (300) @(negedge i_sys_clk);
		chk(xd_n == 0 && rx_q.size() == 0, "data without transfer");
		$display("test cid done");
	endtask : t_cid

	task automatic t_lat();
		rsp_val = {88'h0, 8'h0D, 32'h1234_5678, 7'h2A, 1'b1};
		{rsp_bits, rsp_gap, drv_hi} = {8'h30, 8'h14, 32'h0};
		cmd(6'h0D, 32'hA5A5_0F0F, RSP_48, 1'b0, 1'b1, XFER_NONE, 1'b0, KIND_SINGLE);
		chk(o_response[47:0] === rsp_val[47:0] && o_rsp_timeout === 1'b0, "slow response");
		chk(drv_hi > 0, "no push-pull high");
		rsp_gap = 8'h07;
		cmd(6'h0D, 32'hA5A5_0F0F, RSP_48, 1'b0, 1'b0, XFER_NONE, 1'b0, KIND_SINGLE);
		chk(o_rsp_timeout === 1'b1, "late start accepted");
		repeat (200) @(negedge i_sys_clk);
		$display("test latency done");
	endtask : t_lat

	task automatic t_rd();
		{i_sd_card_mode, i_sd_bus_width_sel, i_block_len, i_block_count} = {2'b11, 12'h2, 16'h2};
		{rsp_bits, rsp_gap, rd_blk, xd_n, dlow} = {8'h30, 8'h03, 2'h2, 64'h0};
		rx_q.delete();
		cmd(6'h12, 32'h0000_0100, RSP_48, 1'b0, 1'b0, XFER_START, 1'b1, KIND_MULTI);
		wait_xd();
		rd_blk = 2'h0;
		chk(xd_n == 1 && rx_q.size() == 8 && dlow == 0, "four-lane read");
		chk(o_data_crc_err === 1'b1, "bad data crc passed");
		for (int i = 0; i < 8; i++) chk(rx_q[i] === 4'(5 + i % 4), "read beat");
		chk(o_card_present === 1'b1, "card detect");
		$display("test read done");
	endtask : t_rd

	task automatic t_wr();
		{i_sd_card_mode, i_block_len, i_block_count, i_write_fifo_guard} = {1'b0, 12'h1, 16'h1, 1'b1};
		{take_n, xd_n, hi_lane} = 96'h0;
		cmd(6'h18, 32'h0000_0200, RSP_48, 1'b0, 1'b0, XFER_START, 1'b0, KIND_SINGLE);
		i_fifo_full = 1'b1;
		repeat (3) @(negedge i_sys_clk);
		ck_tg = 0;
		repeat (20) @(negedge i_sys_clk);
		chk(ck_tg == 0 && o_card_clock_pin === 1'b0, "clock ran, fifo full");
		i_fifo_full = 1'b0;
		wait_xd();
		chk(xd_n == 1 && take_n == 8 && hi_lane == 0, "one-lane write");
		$display("test write done");
	endtask : t_wr

	task automatic t_ps();
		int k;
		i_power_save_enable = 1'b1;
		for (int d = 0; d < 3; d++) begin
			i_power_save_divider = 3'(d);
			repeat (40) @(negedge i_sys_clk);
			@(posedge o_card_clock_pin);
			@(negedge i_sys_clk);
			for (k = 0; k < 100 && o_card_clock_pin === 1'b1; k++) @(negedge i_sys_clk);
			chk(k == (1 << d), "idle half period");
		end
		$display("test ps done");
	endtask : t_ps

	task automatic summarize();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : summarize

	initial begin
		{i_host_enable_bit, i_sd_card_mode, i_sd_bus_width_sel, i_power_save_enable} = 4'h0;
		{i_read_fifo_guard, i_write_fifo_guard, i_fifo_full, i_cmd_write, i_open_drain_sel} = 5'h0;
		{i_power_save_divider, i_special_cmd_sel, i_transfer_kind, i_block_len} = 21'h0;
		{i_block_count, i_argument, i_command_index, i_response_kind} = 56'h0;
		{i_transfer_cmd_sel, i_sdio_special_cmd_sel, i_response_latency_sel} = 5'h0;
		{i_transfer_direction, i_tx_data, rd_blk, rsp_bits, rsp_gap, rsp_val} = 159'h0;
		{n_fail, n_compared, cyc, take_n, xd_n, dlow, hi_lane, drv_hi, ck_tg} = 288'h0;
		{i_sys_rst, ck_prev} = 2'b10;
		repeat (16) @(negedge i_sys_clk);
		i_sys_rst = 1'b0;
		t_off();
		i_host_enable_bit = 1'b1;
		repeat (4) @(negedge i_sys_clk);
		t_cid();
		t_lat();
		t_rd();
		t_wr();
		t_ps();
		summarize();
	end
endmodule : tb_chst_card_host
`default_nettype wire
